//--- core/conv_ctrl.v
// conversion control pin logic of a six-channel converter, with an apb register view
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "conv_ctrl_defines.vh"
module conv_ctrl #(
   parameter CONV_CYCLES = (`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   // apb clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // converter control pins
   input  wire        pair_a_start,
   input  wire        pair_b_start,
   input  wire        pair_c_start,
   input  wire        sleep_n,
   input  wire        device_reset,
   input  wire        config_source_select,
   input  wire        span_clock_pin,
   input  wire        word_byte_select,
   input  wire        high_byte_first_select,
   // result read strobe
   input  wire        result_read,
   // status outputs
   output reg         busy_a,
   output reg         busy_b,
   output reg         busy_c,
   output reg         powered,
   output reg         external_clock_active,
   output reg         span_a_wide,
   output reg  [15:0] parallel_data_lines
);
   localparam RESET_MIN_CYCLES = (`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

   // synchronised pins
   wire [2:0] start_sync;
   wire       sleep_n_sync;
   wire       reset_sync;
   pin_sync #(.WIDTH(5), .INIT(5'b01000)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({device_reset, sleep_n, pair_c_start, pair_b_start, pair_a_start}),
      .sync_out ({reset_sync, sleep_n_sync, start_sync})
   );

   // edge detection on the synchronised starts
   reg  [2:0] start_prev_reg;
   wire [2:0] start_rise = start_sync & ~start_prev_reg;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_prev_reg <= 3'b000;
      end else begin
         start_prev_reg <= start_sync;
      end
   end

   // reset pulse width check
   reg [7:0] reset_len_reg;
   reg       reset_short_reg;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_len_reg   <= 8'h00;
         reset_short_reg <= 1'b0;
      end else if (reset_sync) begin
         if (reset_len_reg != 8'hFF) begin
            reset_len_reg <= reset_len_reg + 8'h01;
         end
      end else begin
         if (reset_len_reg != 8'h00) begin
            reset_short_reg <= (reset_len_reg < RESET_MIN_CYCLES[7:0]);
         end
         reset_len_reg <= 8'h00;
      end
   end

   // control register
   reg  [31:0] control_register;
   wire        apb_write = psel && penable && pwrite;
   wire        apb_read  = psel && penable && !pwrite;
   wire        sw_mode   = config_source_select;
   wire        seq_mode  = control_register[`CR_SEQ_BIT];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_register <= `CR_RESET_VALUE;
      end else if (reset_sync) begin
         control_register <= `CR_RESET_VALUE;
      end else if (apb_write && paddr == `ADDR_CONTROL && sw_mode) begin
         control_register <= pwdata;
      end
   end

   // start routing per pair
   reg [2:0] pair_go;
   always @* begin
      pair_go = 3'b000;
      if (!sw_mode) begin
         pair_go = start_rise;
      end else if (seq_mode) begin
         pair_go = start_rise;
      end else begin
         pair_go = {3{start_rise[0]}};
      end
   end

   // the three converter pairs
   wire [2:0]  pair_busy;
   wire [2:0]  pair_done;
   wire [47:0] pair_count;
   genvar p;
   generate
      for (p = 0; p < 3; p = p + 1) begin : g_pair
         pair_converter #(.CYCLES(CONV_CYCLES)) u_pair (
            .pclk    (pclk),
            .presetn (presetn),
            .start   (pair_go[p]),
            .abort   (reset_sync),
            .enable  (sleep_n_sync),
            .busy    (pair_busy[p]),
            .done    (pair_done[p]),
            .count   (pair_count[16*p+15:16*p])
         );
      end
   endgenerate

   // mode-dependent pin functions
   wire ext_clk_next = sw_mode && control_register[`CR_CLOCK_SOURCE_BIT_BIT];
   // a cleared bit or a low pin selects the wide four-times span
   wire span_next    = sw_mode ? !control_register[`CR_SPAN_A_BIT]
                               : !span_clock_pin;

   // result output: word or byte pairs
   reg [15:0] result_reg;
   reg        byte_phase_reg;
   reg [15:0] data_next;
   always @* begin
      data_next = parallel_data_lines;
      if (!word_byte_select) begin
         data_next = result_reg;
      end else if (byte_phase_reg ^ high_byte_first_select) begin
         data_next = {result_reg[15:8], 8'h00};
      end else begin
         data_next = {result_reg[7:0], 8'h00};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_reg     <= 16'h0000;
         byte_phase_reg <= 1'b0;
      end else begin
         if (pair_done[0]) begin
            result_reg     <= pair_count[15:0];
            byte_phase_reg <= 1'b0;
         end else if (result_read && word_byte_select) begin
            byte_phase_reg <= ~byte_phase_reg;
         end
      end
   end

   // registered outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_a                <= 1'b0;
         busy_b                <= 1'b0;
         busy_c                <= 1'b0;
         powered               <= 1'b0;
         external_clock_active <= 1'b0;
         span_a_wide           <= 1'b0;
         parallel_data_lines   <= 16'h0000;
      end else begin
         busy_a                <= pair_busy[0];
         busy_b                <= pair_busy[1];
         busy_c                <= pair_busy[2];
         powered               <= sleep_n_sync;
         external_clock_active <= ext_clk_next && sleep_n_sync;
         span_a_wide           <= span_next;
         parallel_data_lines   <= data_next;
      end
   end

   // apb read mux
   reg [31:0] rd_next;
   reg        err_next;
   always @* begin
      rd_next  = 32'h0000_0000;
      err_next = 1'b0;
      case (paddr)
         `ADDR_CONTROL: rd_next = control_register;
         `ADDR_PINS:    rd_next = {28'h000_0000, high_byte_first_select,
                                   word_byte_select, span_clock_pin, config_source_select};
         `ADDR_STATUS:  rd_next = {24'h00_0000, reset_short_reg, byte_phase_reg, span_a_wide,
                                   external_clock_active, powered, pair_busy};
         `ADDR_COUNT_A: rd_next = {16'h0000, pair_count[15:0]};
         `ADDR_COUNT_B: rd_next = {16'h0000, pair_count[31:16]};
         `ADDR_COUNT_C: rd_next = {16'h0000, pair_count[47:32]};
         `ADDR_RESULT:  rd_next = {16'h0000, result_reg};
         default:       err_next = 1'b1;
      endcase
      if (pwrite && paddr != `ADDR_CONTROL) begin
         err_next = 1'b1;
      end
   end

   // apb answer: no wait state, pready pulses in the first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && err_next;
         if (psel && !penable && !pwrite) begin
            prdata <= rd_next;
         end
      end
   end
endmodule // conv_ctrl

//--- inc/conv_ctrl_defines.vh
// constants for the conversion control pin logic
`ifndef CONV_CTRL_DEFINES_VH
`define CONV_CTRL_DEFINES_VH
`define CR_RESET_VALUE      32'h0000_03FF
`define CR_SEQ_BIT          23
`define CR_CLOCK_SOURCE_BIT_BIT       11
`define CR_SPAN_A_BIT       26
`define ADDR_CONTROL        12'h000
`define ADDR_PINS           12'h004
`define ADDR_STATUS         12'h008
`define ADDR_COUNT_A        12'h00C
`define ADDR_COUNT_B        12'h010
`define ADDR_COUNT_C        12'h014
`define ADDR_RESULT         12'h018
`define PIN_CFG_SRC         0
`define PIN_SPAN            1
`define PIN_WIDTH           2
`define PIN_HBF             3
`define ST_CONV_A           0
`define ST_CONV_B           1
`define ST_CONV_C           2
`define ST_POWERED          3
`define ST_EXT_CLK          4
`define ST_SPAN_A           5
`define ST_BYTE_PHASE       6
`define CONV_TIME_NS        32'd1000
`define CLK_PERIOD_NS       32'd4
`define RESET_MIN_NS        32'd50
`endif

//--- core/pin_sync.v
// two-flop synchroniser bank for asynchronous control pins
`timescale 1ns/1ns
module pin_sync #(
   parameter WIDTH = 4,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   // clock and reset
   input  wire             pclk,
   input  wire             presetn,
   // pins
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg meta_reg;
         reg sync_reg;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_reg <= INIT[i];
               sync_reg <= INIT[i];
            end else begin
               meta_reg <= async_in[i];
               sync_reg <= meta_reg;
            end
         end
         assign sync_out[i] = sync_reg;
      end
   endgenerate
endmodule // pin_sync

//--- core/pair_converter.v
// one channel pair: busy timer started by a start pulse, abortable
`timescale 1ns/1ns
module pair_converter #(
   parameter CYCLES = 250,
   parameter CW     = 16
) (
   // clock and reset
   input  wire          pclk,
   input  wire          presetn,
   // control
   input  wire          start,
   input  wire          abort,
   input  wire          enable,
   // status
   output reg           busy,
   output reg           done,
   output reg  [15:0]   count
);
   reg [CW-1:0] timer_reg;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy      <= 1'b0;
         done      <= 1'b0;
         timer_reg <= {CW{1'b0}};
         count     <= 16'h0000;
      end else begin
         done <= 1'b0;
         if (abort || !enable) begin
            busy      <= 1'b0;
            timer_reg <= {CW{1'b0}};
         end else if (busy) begin
            if (timer_reg == CYCLES - 1) begin
               busy  <= 1'b0;
               done  <= 1'b1;
               count <= count + 16'h0001;
            end
            timer_reg <= timer_reg + {{(CW-1){1'b0}}, 1'b1};
         end else if (start) begin
            busy      <= 1'b1;
            timer_reg <= {CW{1'b0}};
         end
      end
   end
endmodule // pair_converter

//--- sim/conv_ctrl_properties.sv
// pin-level assertions for the conversion control block
`timescale 1ns/1ns
module conv_ctrl_properties (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // pins
   input wire pair_a_start,
   input wire pair_b_start,
   input wire pair_c_start,
   input wire sleep_n,
   input wire device_reset,
   input wire config_source_select,
   input wire span_clock_pin,
   // status
   input wire busy_a,
   input wire busy_b,
   input wire busy_c,
   input wire powered,
   input wire external_clock_active,
   input wire span_a_wide
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   start_a_busy_a: assert property (
      $rose(pair_a_start) && !busy_a && powered && !device_reset |-> ##[1:7] busy_a)
      else $error("pair a start gave no conversion");
   start_b_busy_a: assert property (
      $rose(pair_b_start) && !config_source_select && !busy_b && powered && !device_reset
      |-> ##[1:7] busy_b) else $error("pair b start gave no conversion");
   start_c_busy_a: assert property (
      $rose(pair_c_start) && !config_source_select && !busy_c && powered && !device_reset
      |-> ##[1:7] busy_c) else $error("pair c start gave no conversion");
   sleep_power_a: assert property (
      $fell(sleep_n) |-> ##[1:3] !powered) else $error("sleep did not power down");
   sleep_idle_a: assert property (
      !powered |-> ##[0:2] !(busy_a || busy_b || busy_c)) else $error("busy while asleep");
   reset_abort_a: assert property (
      device_reset [*5] |-> !(busy_a || busy_b || busy_c)) else $error("reset kept busy");
   hw_span_wide_a: assert property (
      (!config_source_select && !span_clock_pin) [*4] |-> span_a_wide)
      else $error("span pin low not wide");
   hw_span_pin_a: assert property (
      (!config_source_select && span_clock_pin) [*4] |-> !span_a_wide)
      else $error("span pin high gave wide span");
   hw_no_external_conversion_clock_a: assert property (
      !config_source_select [*4] |-> !external_clock_active)
      else $error("external clock in hardware mode");
endmodule // conv_ctrl_properties
bind conv_ctrl conv_ctrl_properties chk_u (.pclk(pclk), .presetn(presetn),
   .pair_a_start(pair_a_start), .pair_b_start(pair_b_start), .pair_c_start(pair_c_start),
   .sleep_n(sleep_n), .device_reset(device_reset), .config_source_select(config_source_select),
   .span_clock_pin(span_clock_pin), .busy_a(busy_a), .busy_b(busy_b), .busy_c(busy_c),
   .powered(powered), .external_clock_active(external_clock_active),
   .span_a_wide(span_a_wide));

//--- sim/pin_host_model.sv
// host model that drives the start pins and the device reset pin
`timescale 1ns/1ns
module pin_host_model (
   // clock
   input  wire       pclk,
   // requests from the bench
   input  wire [2:0] go,
   input  wire       rst_go,
   // converter pins
   output reg  [2:0] starts = 3'h0,
   output reg        device_reset = 1'b0
);
   reg [3:0] s_cnt = 4'h0;
   reg [4:0] r_cnt = 5'h00;
   always @(posedge pclk) begin
      if (go != 3'h0) begin
         starts <= go;
         s_cnt  <= 4'h4;
      end else if (s_cnt != 4'h0) begin
         s_cnt <= s_cnt - 4'h1;
         if (s_cnt == 4'h1) begin
            starts <= 3'h0;
         end
      end
      // 16 cycles of reset, well over the minimum pulse width
      if (rst_go) begin
         device_reset <= 1'b1;
         r_cnt        <= 5'h0F;
      end else if (r_cnt != 5'h00) begin
         r_cnt <= r_cnt - 5'h01;
      end else begin
         device_reset <= 1'b0;
      end
   end
endmodule // pin_host_model

//--- sim/adc_conversion_control_pins_tb_top.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ns
module adc_conversion_control_pins_tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rst_go = 0, se;
   logic sleep_n = 1, cfg = 0, span = 0, wbs = 0, hbf = 0, result_read = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic [2:0] go = 3'h0, starts;
   logic pready, pslverr, busy_a, busy_b, busy_c, powered, ext, wide, device_reset;
   logic [15:0] pdl;
   logic [3:0] rows [0:3] = '{4'h2, 4'h4, 4'hA, 4'hE};
   logic [9:0] brow [0:3] = '{10'h100, 10'h003, 10'h200, 10'h203};
   integer err_count = 0, checks = 0, i;
   conv_ctrl #(.CONV_CYCLES(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pair_a_start(starts[0]), .pair_b_start(starts[1]),
      .pair_c_start(starts[2]), .sleep_n(sleep_n), .device_reset(device_reset),
      .config_source_select(cfg), .span_clock_pin(span), .word_byte_select(wbs),
      .high_byte_first_select(hbf), .result_read(result_read), .busy_a(busy_a),
      .busy_b(busy_b), .busy_c(busy_c), .powered(powered), .external_clock_active(ext),
      .span_a_wide(wide), .parallel_data_lines(pdl));
   pin_host_model host_u (.pclk(pclk), .go(go), .rst_go(rst_go), .starts(starts),
      .device_reset(device_reset));
   always #2 pclk = ~pclk;
   task report_and_stop;
      begin
         $display("checks %0d err_count %0d", checks, err_count);
         if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
         end else begin
            $display("== FAILED ==");
         end
         $finish;
      end
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      integer n;
      begin
         n = 0;
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n = n + 1;
         end
         chk("apb wait", 0, (n == 20));
         q = prdata;
         se = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task conv(input logic [2:0] g, input logic [2:0] m);
      begin
         go <= g;
         @(posedge pclk);
         go <= 3'h0;
         repeat (9) @(posedge pclk);
         chk("busy", m, {busy_c, busy_b, busy_a});
         repeat (14) @(posedge pclk);
      end
   endtask
   initial begin
      #40000;
      err_count = err_count + 1;
      report_and_stop;
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 4; i++) begin
         cfg <= rows[i][3];
         span <= rows[i][2];
         repeat (5) @(posedge pclk);
         chk("span", rows[i][1], wide);
         chk("external_conversion_clock", rows[i][0], ext);
      end
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk("control", 32'h0000_03FF, q);
      apb(1'b1, 12'h000, 32'h0400_0BFF);
      repeat (4) @(posedge pclk);
      chk("span bit", 0, wide);
      chk("external_conversion_clock bit", 1, ext);
      apb(1'b1, 12'h000, 32'h0000_03FF);
      apb(1'b0, 12'h0FC, 32'h0000_0000);
      chk("unmapped", 1, se);
      cfg <= 1'b0;
      apb(1'b1, 12'h000, 32'h0400_0000);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk("hw write", 32'h0000_03FF, q);
      conv(3'h1, 3'h1);
      conv(3'h2, 3'h2);
      conv(3'h4, 3'h4);
      cfg <= 1'b1;
      conv(3'h1, 3'h7);
      conv(3'h2, 3'h0);
      apb(1'b1, 12'h000, 32'h0080_03FF);
      conv(3'h1, 3'h1);
      conv(3'h2, 3'h2);
      conv(3'h4, 3'h4);
      for (i = 0; i < 3; i++) begin
         apb(1'b0, 12'h00C + 12'h004 * i[11:0], 32'h0000_0000);
         chk("count", 3, q);
      end
      chk("word", 3, pdl);
      wbs <= 1'b1;
      for (i = 0; i < 4; i++) begin
         hbf <= brow[i][8];
         result_read <= brow[i][9];
         @(posedge pclk);
         result_read <= 1'b0;
         repeat (3) @(posedge pclk);
         chk("byte", brow[i][7:0], pdl[15:8]);
      end
      go <= 3'h1;
      @(posedge pclk);
      go <= 3'h0;
      repeat (8) @(posedge pclk);
      rst_go <= 1'b1;
      @(posedge pclk);
      rst_go <= 1'b0;
      repeat (20) @(posedge pclk);
      chk("abort", 0, busy_a);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk("reload", 32'h0000_03FF, q);
      go <= 3'h1;
      @(posedge pclk);
      go <= 3'h0;
      repeat (8) @(posedge pclk);
      sleep_n <= 1'b0;
      repeat (5) @(posedge pclk);
      chk("asleep", 0, {powered, busy_c, busy_b, busy_a});
      sleep_n <= 1'b1;
      repeat (5) @(posedge pclk);
      chk("awake", 1, powered);
      report_and_stop;
   end
endmodule // adc_conversion_control_pins_tb_top
